//--- ddb_sram_port.sv
// ddb_sram_port: device side of a burst-of-two ddr sram port
// assumes k, k_n and every pin arrive asynchronously to clk and
// are much slower than clk (k period at least 16 clk cycles)
`timescale 1ns/100ps
module ddb_sram_port import ddb_pkg::*; #(
   parameter int ADDR_W   = ADDR_W_DEF,
   parameter int LOCK_CYC = LOCK_CYC_DEF
) (
   input  logic              clk,
   input  logic              reset_n,
   input  logic              k,
   input  logic              k_n,
   input  logic              load_strobe_n,
   input  logic              rw,
   input  logic [LANES-1:0]  lane_write_sel_n,
   input  logic [ADDR_W-1:0] addr,
   input  logic [WORD_W-1:0] d_in,
   input  logic              pll_bypass_n,
   output logic [WORD_W-1:0] q_out,
   output logic              q_oe,
   output logic              echo_timing,
   output logic              echo_timing_n,
   output logic              read_valid_flag,
   output logic              pll_locked,
   output logic              impedance_update
);
   localparam int AW    = ADDR_W + 1;
   localparam int PIN_W = PIN_A + ADDR_W;
   localparam int ENT_W = AW + LANES + WORD_W;
   localparam int LK_W  = $clog2(LOCK_CYC + 1);
   // clock stages start at the park level so a parked pin gives no edge after reset
   localparam logic [PIN_W-1:0] SYNC_RST = PIN_W'({K_PARK, K_PARK});
   if (ADDR_W < 1 || ADDR_W > 20) begin : g_bad_addr
      $error("ADDR_W out of range");
   end
   if (LOCK_CYC < 1) begin : g_bad_lock
      $error("LOCK_CYC must be positive");
   end

   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] base,
                                               input logic [WORD_W-1:0] nd,
                                               input logic [LANES-1:0]  en);
      logic [WORD_W-1:0] r;
      r = base;
      for (int i = 0; i < LANES; i++) begin
         if (en[i]) r[i*LANE_W +: LANE_W] = nd[i*LANE_W +: LANE_W];
      end
      return r;
   endfunction

   // ==========================================================
   // pin synchronisers
   logic [PIN_W-1:0] s1_reg;
   logic [PIN_W-1:0] s2_reg;
   logic [PIN_W-1:0] s3_reg;
   logic [1:0]       k_f_reg;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s1_reg <= SYNC_RST;
         s2_reg <= SYNC_RST;
         s3_reg <= SYNC_RST;
      end else begin
         s1_reg <= {addr, d_in, pll_bypass_n, lane_write_sel_n, rw, load_strobe_n, k_n, k};
         s2_reg <= s1_reg;
         s3_reg <= s2_reg;
      end
   end
   // only the clocks need the agree filter; other pins are read at clock edges
   always_ff @(posedge clk) begin
      for (int gk = 0; gk < 2; gk++) begin
         if (!reset_n) k_f_reg[gk] <= K_PARK;
         else if (s2_reg[gk] == s3_reg[gk]) k_f_reg[gk] <= s3_reg[gk];
      end
   end
   logic kr_evt, kn_evt, half_evt, cmd_ld, rd_cmd, wr_cmd, pll_mode;
   logic [ADDR_W-1:0] a_pin;
   logic [WORD_W-1:0] d_pin;
   logic [LANES-1:0]  en_pin;
   assign kr_evt   = (s2_reg[PIN_K] == s3_reg[PIN_K]) && s3_reg[PIN_K] && !k_f_reg[0];
   assign kn_evt   = (s2_reg[PIN_KN] == s3_reg[PIN_KN]) && s3_reg[PIN_KN] && !k_f_reg[1];
   assign half_evt = kr_evt || kn_evt;
   assign cmd_ld   = kr_evt && !s3_reg[PIN_LD]; // RULE_22 RULE_24 RULE_25
   assign rd_cmd   = cmd_ld && s3_reg[PIN_RW];
   assign wr_cmd   = cmd_ld && !s3_reg[PIN_RW];
   assign pll_mode = s3_reg[PIN_BYP];
   assign a_pin    = s3_reg[PIN_A +: ADDR_W];
   assign d_pin    = s3_reg[PIN_D +: WORD_W];
   assign en_pin   = ~s3_reg[PIN_SEL +: LANES]; // RULE_01 RULE_19

   // ==========================================================
   // echo clocks
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         echo_timing   <= K_PARK;
         echo_timing_n <= K_PARK;
      end else begin
         echo_timing   <= k_f_reg[0]; // RULE_08
         echo_timing_n <= k_f_reg[1]; // RULE_08
      end
   end

   // ==========================================================
   // write capture and posted-write registers
   logic              wr_arm_reg, wr_cap_reg;
   logic [ADDR_W-1:0] wr_addr_reg, wr_cur_reg;
   logic [WORD_W-1:0] w0_data_reg;
   logic [LANES-1:0]  w0_en_reg;
   logic              pv_reg;
   logic [ADDR_W-1:0] pa_reg;
   logic [WORD_W-1:0] pd_reg [2];
   logic [LANES-1:0]  pe_reg [2];
   logic              pb_busy_reg, pb_sel_reg;
   logic [ADDR_W-1:0] pba_reg;
   logic [WORD_W-1:0] pbd_reg [2];
   logic [LANES-1:0]  pbe_reg [2];
   logic              cap_evt, push_start, fifo_in_ready;
   assign cap_evt    = kn_evt && wr_cap_reg;
   // a posted burst leaves only when a newer burst needs the register
   assign push_start = pv_reg && !pb_busy_reg && (wr_cmd || cap_evt); // RULE_04

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wr_arm_reg  <= 1'b0;
         wr_cap_reg  <= 1'b0;
         wr_addr_reg <= '0;
         wr_cur_reg  <= '0;
         w0_data_reg <= '0;
         w0_en_reg   <= '0;
      end else begin
         if (kr_evt) begin
            wr_arm_reg <= wr_cmd; // RULE_14
            if (wr_cmd) wr_addr_reg <= a_pin;
            if (wr_arm_reg) begin
               wr_cur_reg  <= wr_addr_reg;
               w0_data_reg <= d_pin; // RULE_20
               w0_en_reg   <= en_pin; // RULE_01
            end
         end
         if (kr_evt) wr_cap_reg <= wr_arm_reg;
         else if (kn_evt) wr_cap_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pv_reg <= 1'b0;
         pa_reg <= '0;
         for (int i = 0; i < 2; i++) begin
            pd_reg[i] <= '0;
            pe_reg[i] <= '0;
         end
      end else if (cap_evt) begin
         pv_reg    <= 1'b1; // RULE_04
         pa_reg    <= wr_cur_reg;
         pd_reg[0] <= w0_data_reg;
         pe_reg[0] <= w0_en_reg;
         pd_reg[1] <= d_pin; // RULE_14 RULE_20
         pe_reg[1] <= en_pin; // RULE_01
      end else if (push_start) begin
         pv_reg <= 1'b0;
      end
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         pb_busy_reg <= 1'b0;
         pb_sel_reg  <= 1'b0;
         pba_reg     <= '0;
         for (int i = 0; i < 2; i++) begin
            pbd_reg[i] <= '0;
            pbe_reg[i] <= '0;
         end
      end else if (push_start) begin
         pb_busy_reg <= 1'b1;
         pb_sel_reg  <= 1'b0;
         pba_reg     <= pa_reg;
         pbd_reg     <= pd_reg;
         pbe_reg     <= pe_reg;
      end else if (pb_busy_reg && fifo_in_ready) begin
         pb_sel_reg <= 1'b1;
         if (pb_sel_reg) pb_busy_reg <= 1'b0;
      end
   end

   // ==========================================================
   // posted-write queue and array
   logic             fetch_go;
   logic             fo_valid;
   logic [ENT_W-1:0] fo_data;
   logic [ENT_W-1:0] fi_data;
   logic [WORD_W-1:0] rd_data;
   logic [AW-1:0]    fetch_addr;
   assign fi_data = {pba_reg, pb_sel_reg, pbe_reg[pb_sel_reg], pbd_reg[pb_sel_reg]}; // RULE_17

   ddb_fifo #(.WIDTH(ENT_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (clk),
      .reset_n   (reset_n),
      .in_valid  (pb_busy_reg),
      .in_ready  (fifo_in_ready),
      .in_data   (fi_data),
      .out_valid (fo_valid),
      .out_ready (!fetch_go),
      .out_data  (fo_data)
   );

   // reads own the array; the drain waits, so the queue can back up
   ddb_mem #(.AW(AW)) u_mem (
      .clk     (clk),
      .wr_en   (fo_valid && !fetch_go),
      .wr_lane (fo_data[WORD_W +: LANES]), // RULE_02 RULE_18
      .wr_addr (fo_data[WORD_W+LANES +: AW]),
      .wr_data (fo_data[WORD_W-1:0]),
      .rd_en   (fetch_go),
      .rd_addr (fetch_addr),
      .rd_data (rd_data)
   );

   // ==========================================================
   // read schedule in half-cycle slots
   logic [PLAN_D-1:0] plan_vld_reg;
   logic [AW-1:0]     plan_addr_reg [PLAN_D];
   logic [2:0]        lat;
   assign lat = pll_mode ? 3'(LAT_PLL) : 3'(LAT_DDR1); // RULE_13 RULE_15

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         plan_vld_reg <= '0;
         for (int i = 0; i < PLAN_D; i++) plan_addr_reg[i] <= '0;
      end else if (half_evt) begin
         for (int i = 0; i < PLAN_D - 1; i++) begin
            plan_vld_reg[i]  <= plan_vld_reg[i+1];
            plan_addr_reg[i] <= plan_addr_reg[i+1];
         end
         plan_vld_reg[PLAN_D-1] <= 1'b0;
         if (rd_cmd) begin
            plan_vld_reg[lat]        <= 1'b1; // RULE_15 RULE_24
            plan_addr_reg[lat]       <= {a_pin, 1'b0}; // RULE_17
            plan_vld_reg[lat+3'd1]   <= 1'b1;
            plan_addr_reg[lat+3'd1]  <= {a_pin, 1'b1}; // RULE_17
         end
      end
   end

   logic              half_d1_reg, fetch_d1_reg;
   logic [AW-1:0]     fetch_a1_reg;
   logic [WORD_W-1:0] fetch_word_reg;
   logic [WORD_W-1:0] byp_pb, byp_all;
   logic              hit_pv, hit_pb;
   assign fetch_go   = half_d1_reg && plan_vld_reg[1];
   assign fetch_addr = plan_addr_reg[1];
   assign hit_pv = pv_reg && (pa_reg == fetch_a1_reg[AW-1:1]);
   assign hit_pb = pb_busy_reg && (pba_reg == fetch_a1_reg[AW-1:1]);
   assign byp_pb = merge(rd_data, pbd_reg[fetch_a1_reg[0]],
                         hit_pb ? pbe_reg[fetch_a1_reg[0]] : '0);
   assign byp_all = merge(byp_pb, pd_reg[fetch_a1_reg[0]],
                          hit_pv ? pe_reg[fetch_a1_reg[0]] : '0); // RULE_05

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         half_d1_reg    <= 1'b0;
         fetch_d1_reg   <= 1'b0;
         fetch_a1_reg   <= '0;
         fetch_word_reg <= '0;
      end else begin
         half_d1_reg  <= half_evt;
         fetch_d1_reg <= fetch_go;
         if (fetch_go) fetch_a1_reg <= fetch_addr;
         if (fetch_d1_reg) fetch_word_reg <= byp_all; // RULE_05
      end
   end

   // ==========================================================
   // output drivers: change only on k or k_n rises
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         q_oe            <= 1'b0; // RULE_16
         q_out           <= '0;
         read_valid_flag <= 1'b0;
      end else if (half_evt) begin // RULE_26
         q_oe            <= plan_vld_reg[1]; // RULE_23 RULE_25
         read_valid_flag <= plan_vld_reg[2]; // RULE_09
         if (plan_vld_reg[1]) q_out <= fetch_word_reg; // RULE_20
      end
   end

   // ==========================================================
   // impedance update timer
   logic [9:0] imp_cnt_reg;
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         imp_cnt_reg      <= '0;
         impedance_update <= 1'b0;
      end else begin
         impedance_update <= kr_evt && (imp_cnt_reg == 10'(IMP_PERIOD - 1)); // RULE_07
         if (kr_evt) imp_cnt_reg <= imp_cnt_reg + 10'h001;
      end
   end

   // ==========================================================
   // lock tracking: a quiet k longer than the stop time restarts it
   logic [3:0]      idle_cnt_reg;
   logic [LK_W-1:0] lock_cnt_reg;
   logic            stopped;
   assign stopped = (idle_cnt_reg >= 4'(STOP_CYC));
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         idle_cnt_reg <= '0;
         lock_cnt_reg <= '0;
         pll_locked   <= 1'b0;
      end else begin
         if (s2_reg[PIN_K] != s3_reg[PIN_K]) idle_cnt_reg <= '0;
         else if (!stopped) idle_cnt_reg <= idle_cnt_reg + 4'h1;
         if (stopped) begin
            lock_cnt_reg <= '0;
            pll_locked   <= 1'b0;
         end else if (lock_cnt_reg != LK_W'(LOCK_CYC)) begin
            lock_cnt_reg <= lock_cnt_reg + 1'b1;
         end else begin
            pll_locked <= 1'b1; // RULE_10
         end
      end
   end

   // ==========================================================
   // checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);

   a_lane_capture: assert property (cap_evt |=> pe_reg[1] == $past(en_pin))  // RULE_01
      else $error("lane enables not taken with second word");
   a_posted_hold: assert property (pv_reg && !push_start && !cap_evt |=> pv_reg)  // RULE_04
      else $error("posted write lost without a newer burst");
   a_bypass_data: assert property (fetch_d1_reg && hit_pv && (&pe_reg[fetch_a1_reg[0]])
      |=> fetch_word_reg == $past(pd_reg[fetch_a1_reg[0]]))  // RULE_05
      else $error("read did not return posted data");
   a_echo_follow: assert property (echo_timing == $past(k_f_reg[0]))  // RULE_08
      else $error("echo clock does not follow k");
   a_valid_lead: assert property ($rose(read_valid_flag) |-> ##[1:40] q_oe)  // RULE_09
      else $error("valid flag without following data");
   a_read_slot: assert property (rd_cmd && pll_mode |=> plan_vld_reg[LAT_PLL]
      && plan_addr_reg[LAT_PLL+1] == {$past(a_pin), 1'b1})  // RULE_15
      else $error("read not scheduled at its latency");
   a_idle_float: assert property (half_evt && !plan_vld_reg[1] |=> !q_oe)  // RULE_25
      else $error("outputs driven with no word due");
   a_imp_period: assert property (impedance_update |-> $past(imp_cnt_reg) == 10'h3FF)  // RULE_07
      else $error("impedance update off period");
   a_lock_time: assert property ($rose(pll_locked) |-> lock_cnt_reg == LK_W'(LOCK_CYC))  // RULE_10
      else $error("lock before lock time");
   a_power_float: assert property ($rose(reset_n) |-> !q_oe)  // RULE_16
      else $error("outputs driven at power-up");

   c_read_burst: cover property (rd_cmd ##[1:120] q_oe);
   c_write_burst: cover property (wr_cmd ##[1:60] cap_evt);
   c_bypass: cover property (fetch_d1_reg && hit_pv);
   c_locked: cover property ($rose(pll_locked));
endmodule // ddb_sram_port

//--- ddb_pkg.sv
// constants for the burst-of-two ddr sram port
// assumes one core clock at 250 MHz sampling all pins
//
// Behaviour
// [RULE_01] lane selects sampled with each data word
// [RULE_02] selected lane stored, unselected lane kept
// [RULE_03] controller leaves two idle cycles read-to-write
// [RULE_04] write held posted until next write
// [RULE_05] read of just-written address returns newest data
// [RULE_06] controller drives one load strobe per bank
// [RULE_07] impedance update every 1024 cycles
// [RULE_08] two free-running echo clocks follow inputs
// [RULE_09] valid flag leads read data half cycle
// [RULE_10] lock after stable clock lock time
// [RULE_11] controller stops clocks 30 ns to relock
// [RULE_12] controller keeps clock within lock range
// [RULE_13] bypass input low gives one-cycle latency
// [RULE_14] write data on k then k_n of t+1
// [RULE_15] read data k_n t+2 then k t+3
// [RULE_16] powers up deselected, outputs high impedance
// [RULE_17] burst uses address A then A+1
// [RULE_18] lane 0 bits 8:0, lane 1 bits 17:9
// [RULE_19] controller may change selects between words
// [RULE_20] data taken and launched on both rises
// [RULE_21] controller parks stopped clocks high; ddb_ctrl_model stops k low, k_n high
// [RULE_22] controls sampled on rising k
// [RULE_23] deselect tristates after next k_n rise
// [RULE_24] new command accepted every rising k
// [RULE_25] strobe high starts nothing, outputs float
// [RULE_26] stopped clock holds outputs and posted data
package ddb_pkg;
   localparam int WORD_W       = 18;
   localparam int LANE_W       = 9;
   localparam int LANES        = 2;
   localparam int ADDR_W_DEF   = 10;
   localparam int CLK_MHZ      = 250;
   localparam int CLK_PS       = 4000;
   localparam int LOCK_TIME_US = 20;
   localparam int LOCK_CYC_DEF = LOCK_TIME_US * CLK_MHZ;
   localparam int STOP_TIME_PS = 30000;
   localparam int STOP_CYC     = (STOP_TIME_PS + CLK_PS - 1) / CLK_PS;
   localparam int IMP_PERIOD   = 1024;
   localparam int PLAN_D       = 8;
   localparam int LAT_PLL      = 5;
   localparam int LAT_DDR1     = 2;
   localparam int FIFO_DEPTH   = 32;
   // positions inside the synchronised pin vector
   localparam int PIN_K        = 0;
   localparam int PIN_KN       = 1;
   localparam int PIN_LD       = 2;
   localparam int PIN_RW       = 3;
   localparam int PIN_SEL      = 4;
   localparam int PIN_BYP      = 6;
   localparam int PIN_D        = 7;
   localparam int PIN_A        = PIN_D + WORD_W;
   localparam logic K_PARK     = 1'b1;
endpackage

//--- ddb_fifo.sv
// ddb_fifo: posted-write queue between the pin side and the array
// assumes one clock; drain side may stall for array reads
`timescale 1ns/100ps
module ddb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  logic             clk,
   input  logic             reset_n,
   input  logic             in_valid,
   output logic             in_ready,
   input  logic [WIDTH-1:0] in_data,
   output logic             out_valid,
   input  logic             out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = $clog2(DEPTH);
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_bad_depth
      $error("fifo depth must be a power of two");
   end
   logic [WIDTH-1:0] mem_reg [DEPTH];
   logic [PW-1:0]    wp_reg;
   logic [PW-1:0]    rp_reg;
   logic [PW:0]      cnt_reg;
   logic             push;
   logic             pop;
   // full exactly when the count reaches DEPTH, the only value with the top bit set
   assign in_ready  = !cnt_reg[PW];
   assign out_valid = (cnt_reg != '0);
   assign out_data  = mem_reg[rp_reg];
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   always_ff @(posedge clk) begin
      if (push) begin
         mem_reg[wp_reg] <= in_data;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         wp_reg  <= '0;
         rp_reg  <= '0;
         cnt_reg <= '0;
      end else begin
         if (push) wp_reg <= wp_reg + 1'b1;
         if (pop) rp_reg <= rp_reg + 1'b1;
         cnt_reg <= cnt_reg + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule // ddb_fifo

//--- ddb_mem.sv
// ddb_mem: word array with per-lane write enables, registered read
// assumes read and write never fall in the same cycle
`timescale 1ns/100ps
module ddb_mem import ddb_pkg::*; #(
   parameter int AW = 11
) (
   input  logic              clk,
   input  logic              wr_en,
   input  logic [LANES-1:0]  wr_lane,
   input  logic [AW-1:0]     wr_addr,
   input  logic [WORD_W-1:0] wr_data,
   input  logic              rd_en,
   input  logic [AW-1:0]     rd_addr,
   output logic [WORD_W-1:0] rd_data
);
   logic [WORD_W-1:0] arr_reg [2**AW];
   // one process for all lanes, so the array keeps a single driver
   always_ff @(posedge clk) begin
      for (int gl = 0; gl < LANES; gl++) begin
         if (wr_en && wr_lane[gl]) begin
            arr_reg[wr_addr][gl*LANE_W +: LANE_W] <= wr_data[gl*LANE_W +: LANE_W];
         end
      end
   end
   always_ff @(posedge clk) begin
      if (rd_en) rd_data <= arr_reg[rd_addr];
   end
endmodule // ddb_mem

//--- ddb_ctrl_model.sv
// ddb_ctrl_model: memory controller facing the burst-of-two port, makes k and k_n
// assumes clk at 250 MHz; one k cycle is 16 clk; obs packs {q,oe,valid,echo,echo_n}
`timescale 1ns/100ps
module ddb_ctrl_model import ddb_pkg::*; #(
   parameter int ADDR_W = ADDR_W_DEF
) (
   input  logic              clk,
   input  logic [WORD_W+3:0] obs,
   output logic              k,
   output logic              k_n,
   output logic              load_strobe_n,
   output logic              rw,
   output logic [LANES-1:0]  lane_write_sel_n,
   output logic [ADDR_W-1:0] addr,
   output logic [WORD_W-1:0] d_in
);
   logic              pend;
   logic [WORD_W-1:0] pw0, pw1;
   logic [LANES-1:0]  ps0, ps1;

   // ======================================================================
   // pin drive
   initial begin
      k = 1'b0;
      k_n = 1'b1;
      load_strobe_n = 1'b1;
      rw = 1'b0;
      lane_write_sel_n = 2'h3;
      addr = '0;
      d_in = '0;
      pend = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // pins move 4 clk away from any k edge so the 3-flop sync never sees them mid-change;
   // unused address, rw and data lines carry the inverse of their last value rather than a stale copy; unused lane selects sit high
   task automatic cyc(input logic ld_n, input logic r, input logic [ADDR_W-1:0] a,
                      input logic [WORD_W-1:0] w0, input logic [WORD_W-1:0] w1,
                      input logic [LANES-1:0] s0, input logic [LANES-1:0] s1,
                      output logic [WORD_W+3:0] sn, output logic [WORD_W+3:0] sk);
      tick(4);
      load_strobe_n = ld_n;
      rw = ld_n ? ~rw : r;
      addr = ld_n ? ~addr : a;
      d_in = pend ? pw0 : ~d_in;
      lane_write_sel_n = pend ? ps0 : 2'h3;
      tick(3);
      sn = obs;
      tick(1);
      k = 1'b1;
      k_n = 1'b0;
      tick(4);
      d_in = pend ? pw1 : ~d_in;
      lane_write_sel_n = pend ? ps1 : 2'h3;
      pend = !ld_n && !r;
      {pw0, pw1, ps0, ps1} = {w0, w1, s0, s1};
      tick(3);
      sk = obs;
      tick(1);
      k = 1'b0;
      k_n = 1'b1;
   endtask
endmodule // ddb_ctrl_model

//--- ddb_sram_port_tb_top.sv
// ddb_sram_port_tb_top: self-checking bench for the burst-of-two port
// assumes ddb_ctrl_model drives the pins; a shadow memory gives every expected word
`timescale 1ns/100ps
module ddb_sram_port_tb_top import ddb_pkg::*;;
   localparam int AW = 4;
   localparam int NE = 8192;
   logic              clk, reset_n, k, k_n, load_strobe_n, rw, pll_bypass_n, q_oe;
   logic              echo_timing, echo_timing_n, read_valid_flag, pll_locked;
   logic              impedance_update;
   logic [LANES-1:0]  lane_write_sel_n;
   logic [AW-1:0]     addr;
   logic [WORD_W-1:0] d_in, q_out;
   logic [WORD_W-1:0] mem [0:2*(2**AW)-1];
   logic [WORD_W-1:0] eq [0:NE-1];
   bit                eo [0:NE-1];
   bit                ev [0:NE-1];
   int                mismatches, comparisons, cyc_n, since_rd, kr, kr_last;
   logic [WORD_W+3:0] obs, snap;
   assign obs = {q_out, q_oe, read_valid_flag, echo_timing, echo_timing_n};

   ddb_sram_port #(.ADDR_W(AW), .LOCK_CYC(50)) i_ddb_sram_port (.clk(clk), .reset_n(reset_n),
      .k(k), .k_n(k_n), .load_strobe_n(load_strobe_n), .rw(rw),
      .lane_write_sel_n(lane_write_sel_n), .addr(addr), .d_in(d_in),
      .pll_bypass_n(pll_bypass_n), .q_out(q_out), .q_oe(q_oe), .echo_timing(echo_timing),
      .echo_timing_n(echo_timing_n), .read_valid_flag(read_valid_flag),
      .pll_locked(pll_locked), .impedance_update(impedance_update));
   ddb_ctrl_model #(.ADDR_W(AW)) i_ddb_ctrl_model (.clk(clk), .obs(obs), .k(k), .k_n(k_n),
      .load_strobe_n(load_strobe_n), .rw(rw), .lane_write_sel_n(lane_write_sel_n),
      .addr(addr), .d_in(d_in));

   // ======================================================================
   // clock, watchdog and impedance monitor
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial begin
      #300us;
      mismatches++;
      $display("[FAIL] run length expected end seen timeout");
      conclude();
   end
   always @(posedge k) kr++;
   // sampled mid-cycle so the pulse is read where it is settled
   always @(negedge clk) begin
      if (reset_n && impedance_update) begin
         cmp("impedance_update spacing", WORD_W'(IMP_PERIOD), WORD_W'(kr - kr_last));
         kr_last = kr;
      end
   end

   // ======================================================================
   // checking helpers
   function automatic logic [WORD_W-1:0] merge(input logic [WORD_W-1:0] o, n,
                                               input logic [LANES-1:0] s);
      merge = o;
      if (!s[0]) merge[LANE_W-1:0] = n[LANE_W-1:0];
      if (!s[1]) merge[WORD_W-1:LANE_W] = n[WORD_W-1:LANE_W];
   endfunction

   task automatic cmp(input string what, input logic [WORD_W-1:0] exp, got);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // even events are k rises, odd ones k_n rises; echoes mirror the pin levels
   task automatic chk(input int e, input logic [WORD_W+3:0] s);
      if (e >= 0) begin
         if (eo[e]) cmp("q_out", eq[e], s[WORD_W+3:4]);
         cmp("q_oe", WORD_W'(eo[e]), WORD_W'(s[3]));
         cmp("read_valid_flag", WORD_W'(ev[e]), WORD_W'(s[2]));
         cmp("echo", WORD_W'(e[0] ? 2'h1 : 2'h2), WORD_W'(s[1:0]));
      end
   endtask

   task automatic op(input logic ld_n, input logic r, input logic [AW-1:0] a,
                     input logic [WORD_W-1:0] w0, w1, input logic [LANES-1:0] s0, s1);
      int                e;
      logic [WORD_W+3:0] sn, sk;
      if (!ld_n && r) begin
         e = 2 * cyc_n + (pll_bypass_n ? LAT_PLL : LAT_DDR1);
         eq[e] = mem[{a, 1'b0}];
         eq[e+1] = mem[{a, 1'b1}];
         {eo[e], eo[e+1], ev[e-1], ev[e]} = 4'hF;
      end
      if (!ld_n && !r) begin
         mem[{a, 1'b0}] = merge(mem[{a, 1'b0}], w0, s0);
         mem[{a, 1'b1}] = merge(mem[{a, 1'b1}], w1, s1);
      end
      since_rd = (!ld_n && r) ? 1 : since_rd + 1;
      i_ddb_ctrl_model.cyc(ld_n, r, a, w0, w1, s0, s1, sn, sk);
      chk(2 * cyc_n - 1, sn);
      chk(2 * cyc_n, sk);
      cyc_n++;
   endtask

   task automatic nop();
      op(1'b1, 1'b0, '0, '0, '0, 2'h3, 2'h3);
   endtask
   task automatic rd(input logic [AW-1:0] a);
      op(1'b0, 1'b1, a, '0, '0, 2'h3, 2'h3);
   endtask
   task automatic wr(input logic [AW-1:0] a, input logic [LANES-1:0] s0, s1);
      op(1'b0, 1'b0, a, WORD_W'($urandom), WORD_W'($urandom), s0, s1);
   endtask
   task automatic rnd_op();
      int p;
      p = $urandom_range(7);
      if (p < 2) nop();
      else if (p < 5 && since_rd >= 3) wr(AW'($urandom), 2'($urandom), 2'($urandom));
      else rd(AW'($urandom));
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask

   // ======================================================================
   // test sequence
   initial begin
      reset_n = 1'b0;
      pll_bypass_n = 1'b1;
      {mismatches, comparisons, cyc_n} = '0;
      since_rd = 8;
      repeat (10) @(posedge clk);
      #1 reset_n = 1'b1;
      void'($urandom(75));
      // back-to-back writes fill every word, then back-to-back reads
      for (int i = 0; i < 2**AW; i++) wr(AW'(i), 2'h0, 2'h0);
      for (int i = 0; i < 2**AW; i++) rd(AW'(i));
      $display("test fill done");
      // every lane code on each word, read straight after the write
      for (int i = 0; i < 4; i++) begin
         nop();
         nop();
         wr(4'h3, 2'(i), 2'(3 - i));
         rd(4'h3);
      end
      $display("test lanes done");
      // write then stop the clock with a read in flight; posted data must survive
      nop();
      nop();
      cmp("pll_locked", WORD_W'(1), WORD_W'(pll_locked));
      wr(4'h5, 2'h0, 2'h0);
      rd(4'h6);
      i_ddb_ctrl_model.tick(8);
      snap = obs;
      i_ddb_ctrl_model.tick(12);
      cmp("held outputs", snap[WORD_W+3:4], q_out);
      cmp("held flags", WORD_W'(snap[3:0]), WORD_W'(obs[3:0]));
      cmp("pll_locked", WORD_W'(0), WORD_W'(pll_locked));
      repeat (6) nop();
      cmp("pll_locked", WORD_W'(1), WORD_W'(pll_locked));
      rd(4'h5);
      $display("test stop done");
      // legacy single-rate timing
      repeat (4) nop();
      pll_bypass_n = 1'b0;
      repeat (60) rnd_op();
      repeat (4) nop();
      pll_bypass_n = 1'b1;
      $display("test legacy done");
      // long random traffic also spans two impedance periods
      repeat (2200) rnd_op();
      repeat (4) nop();
      cmp("impedance periods", WORD_W'(2), WORD_W'(kr_last / IMP_PERIOD));
      $display("test random done");
      conclude();
   end
endmodule // ddb_sram_port_tb_top
